/* dmc_pkg.sv */
package dmc_pkg;

   // Register byte offsets
   localparam logic [7:0] DMC_OFS_CTRL   = 8'h00;
   localparam logic [7:0] DMC_OFS_STATUS = 8'h04;
   localparam logic [7:0] DMC_OFS_MR0    = 8'h08;
   localparam logic [7:0] DMC_OFS_TIM0   = 8'h18;
   localparam logic [7:0] DMC_OFS_LAST   = 8'h34;
   localparam int         DMC_NUM_MR     = 4;
   localparam int         DMC_NUM_TIM    = 8;

   // Control fields
   localparam int DMC_CTRL_GO      = 0;
   localparam int DMC_CTRL_OP_LSB  = 1;
   localparam int DMC_CTRL_ODT_EN  = 3;
   localparam int DMC_CTRL_VFLOAT  = 4;

   // Status fields
   localparam int DMC_ST_BUSY      = 0;
   localparam int DMC_ST_DLL_OFF   = 1;
   localparam int DMC_ST_WR_INH    = 2;
   localparam int DMC_ST_LOCKING   = 3;
   localparam int DMC_ST_CLK_REQ   = 4;
   localparam int DMC_ST_ERR       = 5;
   localparam int DMC_ST_STATE_LSB = 8;

   // Timing register indices
   localparam logic [2:0] DMC_T_MOD   = 3'h0;
   localparam logic [2:0] DMC_T_MRD   = 3'h1;
   localparam logic [2:0] DMC_T_XS    = 3'h2;
   localparam logic [2:0] DMC_T_XP    = 3'h3;
   localparam logic [2:0] DMC_T_CKSRE = 3'h4;
   localparam logic [2:0] DMC_T_CKSRX = 3'h5;
   localparam logic [2:0] DMC_T_DLLK  = 3'h6;
   localparam logic [2:0] DMC_T_ZQ    = 3'h7;
   localparam logic [15:0] DMC_TIM_RST = 16'h0010;
   localparam logic [15:0] DMC_MR_RST  = 16'h0000;
   localparam logic [15:0] DMC_VREF_WR_CYC = 16'h0200;

   // Mode register fields
   localparam logic [1:0] DMC_MR0 = 2'h0;
   localparam logic [1:0] DMC_MR1 = 2'h1;
   localparam logic [1:0] DMC_MR2 = 2'h2;
   localparam logic [1:0] DMC_MR3 = 2'h3;
   localparam int DMC_MR1_DLL_DIS = 0;
   localparam int DMC_MR0_DLL_RST = 8;
   localparam int DMC_MR1_RTT_A   = 2;
   localparam int DMC_MR1_RTT_B   = 6;
   localparam int DMC_MR1_RTT_C   = 9;
   localparam int DMC_MR2_RWR_LSB = 9;
   localparam int DMC_MR0_CL_LSB  = 4;
   localparam int DMC_MR0_CL_B0   = 2;
   localparam int DMC_MR2_CWL_LSB = 3;
   localparam logic [2:0] DMC_CL6_CODE  = 3'h2;
   localparam logic [2:0] DMC_CWL6_CODE = 3'h1;
   localparam int DMC_ZQ_LONG_BIT = 10;

   typedef enum logic [1:0] {
      DMC_OP_DLL_OFF = 2'h0,
      DMC_OP_DLL_ON  = 2'h1,
      DMC_OP_PPD     = 2'h2
   } dmc_op_t;

   typedef struct packed {
      logic        psel;
      logic        penable;
      logic        pwrite;
      logic [7:0]  paddr;
      logic [31:0] pwdata;
   } dmc_apb_req_t;

   typedef struct packed {
      logic        cke;
      logic        odt;
      logic        cs_n;
      logic        ras_n;
      logic        cas_n;
      logic        we_n;
      logic [2:0]  ba;
      logic [15:0] addr;
   } dmc_ddr_t;

endpackage : dmc_pkg

/* dmc_timer.sv */
`timescale 1ns/1ps
`default_nettype none
module dmc_timer (
   // Clock and reset
   input  wire logic        pclk,
   input  wire logic        presetn,
   input  wire logic        ce,
   // Load and status
   input  wire logic        load,
   input  wire logic [15:0] value,
   output var  logic        done
);
   logic [15:0] cnt_ff;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         cnt_ff <= 16'h0000;
      end else if (ce) begin
         if (load) begin
            cnt_ff <= value;
         end else if (cnt_ff != 16'h0000) begin
            cnt_ff <= cnt_ff - 16'h0001;
         end
      end
   end

   // A load in progress is never reported as expired
   assign done = (cnt_ff == 16'h0000) && !load;
endmodule : dmc_timer
`default_nettype wire

/* dmc_ctrl.sv */
// Contract
// - After floating data reference, no write before 512 clocks past exit.
// - Mode register 1 bit 0 set disables DLL, clear enables it.
// - DLL off allows only read latency 6 and write latency 6.
// - DLL off: ODT held low, nominal and write termination fields zero.
// - Cross DLL-on/DLL-off clock rate gap only inside self refresh.
// - DLL-off order: MR1 write, tMOD, enter SR, tCKSRE, change, tCKSRX, exit, tXS.
// - After DLL-off mode register update wait max(tMRD,tMOD), then long ZQ.
// - DLL-on order: SR, change, exit, tXS, clear MR1 bit, tMRD, DLL reset.
// - No DLL-dependent command until tDLLK after DLL reset; long ZQ follows.
// - Clock only changes in self refresh or precharge power-down.
// - Clock changes after tCKSRE; new clock stable tCKSRX before exit.
// - Frequency-only self refresh still meets all entry and exit timings.
// - Power-down change: termination off, CKE low, tCKSRE before changing clock.
// - CKE stays low through power-down clock change; period within grade.
// - Stable clock tCKSRX before exit; after tXP reset DLL, rewrite registers.
// - Termination stays off while DLL relocks; normal use after lock time.
`timescale 1ns/1ps
`default_nettype none
module dmc_ctrl (
   // Clock, reset, enable
   input  wire logic                 pclk,
   input  wire logic                 presetn,
   input  wire logic                 ce,
   // APB slave
   input  wire dmc_pkg::dmc_apb_req_t apb_req,
   output logic [31:0]               prdata,
   output logic                      pready,
   output logic                      pslverr,
   // DRAM command pins
   output dmc_pkg::dmc_ddr_t         ddr,
   // Clock generator handshake
   output logic                      clk_chg_req,
   input  wire logic                 clk_stable,
   // Write guard to the data path
   output logic                      wr_inhibit
);
   typedef enum logic [4:0] {
      S_IDLE   = 5'h00, S_MR1W  = 5'h01, S_WMOD  = 5'h03, S_ENTER = 5'h02,
      S_WSRE   = 5'h06, S_CHG   = 5'h07, S_WSRX  = 5'h05, S_EXIT  = 5'h04,
      S_WXS    = 5'h0C, S_WMRD  = 5'h0D, S_MR0RS = 5'h0F, S_WMRD2 = 5'h0E,
      S_UPD    = 5'h0A, S_WUPD  = 5'h0B, S_ZQ    = 5'h09, S_WZQ   = 5'h08,
      S_WDLLK  = 5'h18
   } dmc_state_t;

   dmc_state_t       state_ff, nxt_state;
   dmc_pkg::dmc_op_t op_ff;
   dmc_pkg::dmc_ddr_t ddr_ff, nxt_ddr;
   logic [15:0] mr_ff  [dmc_pkg::DMC_NUM_MR];
   logic [15:0] tim_ff [dmc_pkg::DMC_NUM_TIM];
   logic [1:0]  upd_idx_ff;
   logic        odt_en_ff, vfloat_ff, dll_off_ff, err_ff;
   logic        clk_req_ff, sync_meta_ff, sync_ff;
   logic        prdy_ff, perr_ff;
   logic [31:0] prdata_ff;
   logic        t_load, t_done, dllk_load, dllk_done, wg_load, wg_done;
   logic [15:0] t_val, t_max;
   logic        wr_acc, rd_acc, go_req, go_ok, hit_mr, hit_tim, mapped;
   logic [7:0]  ofs_mr, ofs_tim;
   logic [1:0]  upd_sel;
   logic [31:0] rd_word;

   // APB decode, one wait state per access
   assign wr_acc  = apb_req.psel && apb_req.penable && apb_req.pwrite && prdy_ff;
   assign rd_acc  = apb_req.psel && apb_req.penable && !prdy_ff;
   assign ofs_mr  = apb_req.paddr - dmc_pkg::DMC_OFS_MR0;
   assign ofs_tim = apb_req.paddr - dmc_pkg::DMC_OFS_TIM0;
   assign hit_mr  = (apb_req.paddr >= dmc_pkg::DMC_OFS_MR0) &&
                    (apb_req.paddr <  dmc_pkg::DMC_OFS_TIM0);
   assign hit_tim = (apb_req.paddr >= dmc_pkg::DMC_OFS_TIM0) &&
                    (apb_req.paddr <= dmc_pkg::DMC_OFS_LAST);
   assign mapped  = (apb_req.paddr[1:0] == 2'h0) &&
                    (apb_req.paddr <= dmc_pkg::DMC_OFS_LAST);
   assign go_req  = wr_acc && (apb_req.paddr == dmc_pkg::DMC_OFS_CTRL) &&
                    apb_req.pwdata[dmc_pkg::DMC_CTRL_GO];
   // PPD change needs a DLL reset, so it is refused in DLL-off mode
   assign go_ok   = go_req && (state_ff == S_IDLE) &&
                    (apb_req.pwdata[dmc_pkg::DMC_CTRL_OP_LSB +: 2] != 2'h3) &&
                    !((apb_req.pwdata[dmc_pkg::DMC_CTRL_OP_LSB +: 2] == 2'h2) &&
                      dll_off_ff);

   always_comb begin
      rd_word = 32'h0000_0000;
      if (apb_req.paddr == dmc_pkg::DMC_OFS_CTRL) begin
         rd_word[dmc_pkg::DMC_CTRL_OP_LSB +: 2] = op_ff;
         rd_word[dmc_pkg::DMC_CTRL_ODT_EN]      = odt_en_ff;
         rd_word[dmc_pkg::DMC_CTRL_VFLOAT]      = vfloat_ff;
      end else if (apb_req.paddr == dmc_pkg::DMC_OFS_STATUS) begin
         rd_word[dmc_pkg::DMC_ST_BUSY]          = (state_ff != S_IDLE);
         rd_word[dmc_pkg::DMC_ST_DLL_OFF]       = dll_off_ff;
         rd_word[dmc_pkg::DMC_ST_WR_INH]        = !wg_done;
         rd_word[dmc_pkg::DMC_ST_LOCKING]       = !dllk_done;
         rd_word[dmc_pkg::DMC_ST_CLK_REQ]       = clk_req_ff;
         rd_word[dmc_pkg::DMC_ST_ERR]           = err_ff;
         rd_word[dmc_pkg::DMC_ST_STATE_LSB +: 5] = state_ff;
      end else if (hit_mr) begin
         rd_word[15:0] = mr_ff[ofs_mr[3:2]];
      end else if (hit_tim) begin
         rd_word[15:0] = tim_ff[ofs_tim[4:2]];
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdy_ff   <= 1'b0;
         perr_ff   <= 1'b0;
         prdata_ff <= 32'h0000_0000;
      end else if (ce) begin
         prdy_ff   <= rd_acc;
         perr_ff   <= rd_acc && !mapped;
         prdata_ff <= (rd_acc && mapped && !apb_req.pwrite) ? rd_word : 32'h0000_0000;
      end
   end

   // Per-entry register storage, writes land on the pready edge
   for (genvar i = 0; i < dmc_pkg::DMC_NUM_MR; i++) begin : g_mr
      always_ff @(posedge pclk or negedge presetn) begin
         if (!presetn) begin
            mr_ff[i] <= dmc_pkg::DMC_MR_RST;
         end else if (ce && wr_acc && hit_mr && (ofs_mr[3:2] == 2'(i))) begin
            mr_ff[i] <= apb_req.pwdata[15:0];
         end
      end
   end
   for (genvar i = 0; i < dmc_pkg::DMC_NUM_TIM; i++) begin : g_tim
      always_ff @(posedge pclk or negedge presetn) begin
         if (!presetn) begin
            tim_ff[i] <= dmc_pkg::DMC_TIM_RST;
         end else if (ce && wr_acc && hit_tim && (ofs_tim[4:2] == 3'(i))) begin
            tim_ff[i] <= apb_req.pwdata[15:0];
         end
      end
   end

   // Control bits; op is latched only when a start is accepted
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         op_ff     <= dmc_pkg::DMC_OP_DLL_OFF;
         odt_en_ff <= 1'b0;
         vfloat_ff <= 1'b0;
      end else if (ce) begin
         if (wr_acc && (apb_req.paddr == dmc_pkg::DMC_OFS_CTRL)) begin
            odt_en_ff <= apb_req.pwdata[dmc_pkg::DMC_CTRL_ODT_EN];
            vfloat_ff <= apb_req.pwdata[dmc_pkg::DMC_CTRL_VFLOAT];
         end
         if (go_ok) begin
            op_ff <= dmc_pkg::dmc_op_t'(apb_req.pwdata[dmc_pkg::DMC_CTRL_OP_LSB +: 2]);
         end
      end
   end

   // Refused start is sticky; a new refusal beats the clear
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         err_ff <= 1'b0;
      end else if (ce) begin
         if (go_req && !go_ok) begin
            err_ff <= 1'b1;
         end else if (wr_acc && (apb_req.paddr == dmc_pkg::DMC_OFS_STATUS) &&
                      apb_req.pwdata[dmc_pkg::DMC_ST_ERR]) begin
            err_ff <= 1'b0;
         end
      end
   end

   // Clock-stable pin crosses in through two flops
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         sync_meta_ff <= 1'b0;
         sync_ff      <= 1'b0;
      end else if (ce) begin
         sync_meta_ff <= clk_stable;
         sync_ff      <= sync_meta_ff;
      end
   end

   // Mode word with the DLL-off restrictions forced in
   function automatic logic [15:0] mr_word(input logic [1:0] sel, input logic off,
                                           input logic dll_rst);
      logic [15:0] w;
      w = mr_ff[sel];
      unique case (sel)
         dmc_pkg::DMC_MR0: begin
            w[dmc_pkg::DMC_MR0_DLL_RST] = dll_rst;
            if (off) begin
               w[dmc_pkg::DMC_MR0_CL_LSB +: 3] = dmc_pkg::DMC_CL6_CODE;
               w[dmc_pkg::DMC_MR0_CL_B0]       = 1'b0;
            end
         end
         dmc_pkg::DMC_MR1: begin
            w[dmc_pkg::DMC_MR1_DLL_DIS] = off;
            if (off) begin
               w[dmc_pkg::DMC_MR1_RTT_A] = 1'b0;
               w[dmc_pkg::DMC_MR1_RTT_B] = 1'b0;
               w[dmc_pkg::DMC_MR1_RTT_C] = 1'b0;
            end
         end
         dmc_pkg::DMC_MR2: begin
            if (off) begin
               w[dmc_pkg::DMC_MR2_RWR_LSB +: 2] = 2'h0;
               w[dmc_pkg::DMC_MR2_CWL_LSB +: 3] = dmc_pkg::DMC_CWL6_CODE;
            end
         end
         dmc_pkg::DMC_MR3: begin
         end
      endcase
      return w;
   endfunction : mr_word

   assign t_max   = (tim_ff[dmc_pkg::DMC_T_MRD] > tim_ff[dmc_pkg::DMC_T_MOD]) ?
                    tim_ff[dmc_pkg::DMC_T_MRD] : tim_ff[dmc_pkg::DMC_T_MOD];
   // Update list: MR0, MR2, MR3; MR0 skipped once the DLL reset wrote it
   assign upd_sel = (upd_idx_ff == 2'h0) ? dmc_pkg::DMC_MR0 :
                    (upd_idx_ff == 2'h1) ? dmc_pkg::DMC_MR2 : dmc_pkg::DMC_MR3;

   always_comb begin
      nxt_state  = state_ff;
      t_load     = 1'b0;
      t_val      = 16'h0000;
      dllk_load  = 1'b0;
      wg_load    = 1'b0;
      nxt_ddr    = ddr_ff;
      nxt_ddr.cs_n  = 1'b0;
      nxt_ddr.ras_n = 1'b1;
      nxt_ddr.cas_n = 1'b1;
      nxt_ddr.we_n  = 1'b1;
      nxt_ddr.ba    = 3'h0;
      nxt_ddr.addr  = 16'h0000;
      // Termination off in DLL-off, during sequences and while relocking
      nxt_ddr.odt   = (state_ff == S_IDLE) && !go_ok && odt_en_ff && !dll_off_ff &&
                      dllk_done;
      unique case (state_ff)
         S_IDLE: begin
            if (go_ok) begin
               // Only the DLL-off path begins with a mode write
               nxt_state = (apb_req.pwdata[dmc_pkg::DMC_CTRL_OP_LSB +: 2] == 2'h0) ?
                           S_MR1W : S_ENTER;
            end
         end
         S_MR1W: begin
            nxt_ddr.ras_n = 1'b0;
            nxt_ddr.cas_n = 1'b0;
            nxt_ddr.we_n  = 1'b0;
            nxt_ddr.ba    = {1'b0, dmc_pkg::DMC_MR1};
            nxt_ddr.addr  = mr_word(dmc_pkg::DMC_MR1, op_ff == dmc_pkg::DMC_OP_DLL_OFF,
                                    1'b0);
            t_load    = 1'b1;
            t_val     = (op_ff == dmc_pkg::DMC_OP_DLL_OFF) ? tim_ff[dmc_pkg::DMC_T_MOD] :
                        tim_ff[dmc_pkg::DMC_T_MRD];
            nxt_state = (op_ff == dmc_pkg::DMC_OP_DLL_OFF) ? S_WMOD : S_WMRD;
         end
         S_WMOD: if (t_done) nxt_state = S_ENTER;
         S_ENTER: begin
            nxt_ddr.cke = 1'b0;
            if (op_ff != dmc_pkg::DMC_OP_PPD) begin
               nxt_ddr.ras_n = 1'b0;
               nxt_ddr.cas_n = 1'b0;
            end
            t_load    = 1'b1;
            t_val     = tim_ff[dmc_pkg::DMC_T_CKSRE];
            nxt_state = S_WSRE;
         end
         S_WSRE: if (t_done) nxt_state = S_CHG;
         S_CHG: begin
            // CKE stays low throughout the change
            if (sync_ff) begin
               t_load    = 1'b1;
               t_val     = tim_ff[dmc_pkg::DMC_T_CKSRX];
               nxt_state = S_WSRX;
            end
         end
         S_WSRX: if (t_done) nxt_state = S_EXIT;
         S_EXIT: begin
            nxt_ddr.cke = 1'b1;
            t_load    = 1'b1;
            t_val     = (op_ff == dmc_pkg::DMC_OP_PPD) ? tim_ff[dmc_pkg::DMC_T_XP] :
                        tim_ff[dmc_pkg::DMC_T_XS];
            wg_load   = vfloat_ff && (op_ff != dmc_pkg::DMC_OP_PPD);
            nxt_state = S_WXS;
         end
         S_WXS: begin
            if (t_done) begin
               nxt_state = (op_ff == dmc_pkg::DMC_OP_DLL_OFF) ? S_UPD :
                           (op_ff == dmc_pkg::DMC_OP_DLL_ON) ? S_MR1W : S_MR0RS;
            end
         end
         S_WMRD: if (t_done) nxt_state = S_MR0RS;
         S_MR0RS: begin
            nxt_ddr.ras_n = 1'b0;
            nxt_ddr.cas_n = 1'b0;
            nxt_ddr.we_n  = 1'b0;
            nxt_ddr.ba    = {1'b0, dmc_pkg::DMC_MR0};
            nxt_ddr.addr  = mr_word(dmc_pkg::DMC_MR0, 1'b0, 1'b1);
            t_load    = 1'b1;
            t_val     = tim_ff[dmc_pkg::DMC_T_MRD];
            dllk_load = 1'b1;
            nxt_state = S_WMRD2;
         end
         S_WMRD2: if (t_done) nxt_state = S_UPD;
         S_UPD: begin
            nxt_ddr.ras_n = 1'b0;
            nxt_ddr.cas_n = 1'b0;
            nxt_ddr.we_n  = 1'b0;
            nxt_ddr.ba    = {1'b0, upd_sel};
            nxt_ddr.addr  = mr_word(upd_sel, dll_off_ff, 1'b0);
            t_load    = 1'b1;
            t_val     = (upd_idx_ff == 2'h2) ? t_max : tim_ff[dmc_pkg::DMC_T_MRD];
            nxt_state = S_WUPD;
         end
         S_WUPD: begin
            if (t_done) begin
               nxt_state = (upd_idx_ff != 2'h2) ? S_UPD :
                           (op_ff == dmc_pkg::DMC_OP_PPD) ? S_WDLLK : S_ZQ;
            end
         end
         S_ZQ: begin
            nxt_ddr.we_n = 1'b0;
            nxt_ddr.addr[dmc_pkg::DMC_ZQ_LONG_BIT] = 1'b1;
            t_load    = 1'b1;
            t_val     = tim_ff[dmc_pkg::DMC_T_ZQ];
            nxt_state = S_WZQ;
         end
         S_WZQ: if (t_done) nxt_state = S_WDLLK;
         S_WDLLK: if (dllk_done) nxt_state = S_IDLE;
         default: nxt_state = S_IDLE;
      endcase
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         state_ff <= S_IDLE;
      end else if (ce) begin
         state_ff <= nxt_state;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ddr_ff <= '{cke: 1'b1, odt: 1'b0, cs_n: 1'b1, ras_n: 1'b1, cas_n: 1'b1,
                     we_n: 1'b1, ba: 3'h0, addr: 16'h0000};
      end else if (ce) begin
         ddr_ff <= nxt_ddr;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         upd_idx_ff <= 2'h0;
      end else if (ce) begin
         if (state_ff == S_IDLE) begin
            upd_idx_ff <= 2'h0;
         end else if ((state_ff == S_WXS) || (state_ff == S_WMRD2)) begin
            upd_idx_ff <= (op_ff == dmc_pkg::DMC_OP_DLL_OFF) ? 2'h0 : 2'h1;
         end else if ((state_ff == S_WUPD) && t_done) begin
            upd_idx_ff <= upd_idx_ff + 2'h1;
         end
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         dll_off_ff <= 1'b0;
      end else if (ce && (state_ff == S_MR1W)) begin
         dll_off_ff <= (op_ff == dmc_pkg::DMC_OP_DLL_OFF);
      end
   end

   // Request held from tCKSRE expiry until the stable level arrives
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         clk_req_ff <= 1'b0;
      end else if (ce) begin
         clk_req_ff <= (nxt_state == S_CHG);
      end
   end

   dmc_timer u_step (
      .pclk    (pclk),
      .presetn (presetn),
      .ce      (ce),
      .load    (t_load),
      .value   (t_val),
      .done    (t_done)
   );
   dmc_timer u_dllk (
      .pclk    (pclk),
      .presetn (presetn),
      .ce      (ce),
      .load    (dllk_load),
      .value   (tim_ff[dmc_pkg::DMC_T_DLLK]),
      .done    (dllk_done)
   );
   dmc_timer u_wguard (
      .pclk    (pclk),
      .presetn (presetn),
      .ce      (ce),
      .load    (wg_load),
      .value   (dmc_pkg::DMC_VREF_WR_CYC),
      .done    (wg_done)
   );

   // Write guard is registered; the load term raises it with CKE, and it drops one cycle after expiry
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         wr_inhibit <= 1'b0;
      end else if (ce) begin
         wr_inhibit <= wg_load || !wg_done;
      end
   end

   assign prdata      = prdata_ff;
   assign pready      = prdy_ff;
   assign pslverr     = perr_ff;
   assign ddr         = ddr_ff;
   assign clk_chg_req = clk_req_ff;
endmodule : dmc_ctrl
`default_nettype wire

/* dmc_ctrl_assertions.sv */
`timescale 1ns/1ps
`default_nettype none
module dmc_ctrl_chk (
   // Clock and reset
   input wire logic                  pclk,
   input wire logic                  presetn,
   input wire logic                  ce,
   // APB
   input wire dmc_pkg::dmc_apb_req_t apb_req,
   input wire logic [31:0]           prdata,
   input wire logic                  pready,
   input wire logic                  pslverr,
   // DRAM side
   input wire dmc_pkg::dmc_ddr_t     ddr,
   input wire logic                  clk_chg_req,
   input wire logic                  clk_stable,
   input wire logic                  wr_inhibit
);
   logic        dll_off_ff;
   logic [11:0] hi_cnt_ff;
   wire         mrs = !ddr.cs_n && !ddr.ras_n && !ddr.cas_n && !ddr.we_n;
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);
   // Own copy of the DLL state, taken from the mode writes on the pins
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) dll_off_ff <= 1'b0;
      else if (mrs && ddr.ba == 3'h1) dll_off_ff <= ddr.addr[0];
   end
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) hi_cnt_ff <= 12'h000;
      else hi_cnt_ff <= wr_inhibit ? hi_cnt_ff + 12'h001 : 12'h000;
   end
   chk_bad_addr: assert property (pready && apb_req.paddr > 8'h34 |-> pslverr)
      else $error("no error on unmapped access");
   chk_odt_cke_low: assert property (!ddr.cke |-> !ddr.odt)
      else $error("odt high with cke low");
   chk_req_cke_low: assert property (clk_chg_req |-> !ddr.cke && !$past(ddr.cke, 2))
      else $error("clock change outside low power");
   chk_exit_after_clk: assert property ($rose(ddr.cke) |-> !$past(clk_chg_req) && !$past(clk_chg_req, 2))
      else $error("exit before clock settled");
   chk_wr_inh_start: assert property ($rose(wr_inhibit) |-> $rose(ddr.cke))
      else $error("write guard not tied to exit");
   chk_wr_inh_span: assert property ($fell(wr_inhibit) |-> hi_cnt_ff >= 12'h200)
      else $error("write guard too short");
   chk_cl_dll_off: assert property (mrs && dll_off_ff && ddr.ba == 3'h0 |-> ddr.addr[6:4] == dmc_pkg::DMC_CL6_CODE && !ddr.addr[2] && !ddr.addr[8])
      else $error("bad read latency with dll off");
   chk_cwl_dll_off: assert property (mrs && dll_off_ff && ddr.ba == 3'h2 |-> ddr.addr[5:3] == dmc_pkg::DMC_CWL6_CODE && ddr.addr[10:9] == 2'h0)
      else $error("bad write latency or termination");
   chk_mr1_rtt_off: assert property (mrs && ddr.ba == 3'h1 && ddr.addr[0] |-> !ddr.addr[9] && !ddr.addr[6] && !ddr.addr[2])
      else $error("termination left on");
   cov_dll_off: cover property (mrs && ddr.ba == 3'h1 && ddr.addr[0]);
   cov_clk_chg: cover property ($fell(clk_chg_req));
   cov_guard: cover property ($fell(wr_inhibit));
endmodule : dmc_ctrl_chk
bind dmc_ctrl dmc_ctrl_chk dmc_ctrl_chk_i (.pclk(pclk), .presetn(presetn), .ce(ce),
   .apb_req(apb_req), .prdata(prdata), .pready(pready), .pslverr(pslverr), .ddr(ddr),
   .clk_chg_req(clk_chg_req), .clk_stable(clk_stable), .wr_inhibit(wr_inhibit));
`default_nettype wire

/* dmc_dram_model.sv */
`timescale 1ns/1ps
`default_nettype none
module dmc_dram_model (
   // Clock and reset
   input  wire logic              pclk,
   input  wire logic              presetn,
   // Command pins, clock handshake
   input  wire dmc_pkg::dmc_ddr_t ddr,
   input  wire logic              clk_chg_req,
   output logic                   clk_stable,
   // Observed state
   output logic                   dll_off,
   output logic [7:0]             viol
);
   logic       in_sr_ff;
   logic [4:0] cnt_ff;
   logic       slow_ff;
   // Mode writes taken at once, no settle time modelled
   wire        mrs = ddr.cke && !ddr.cs_n && !ddr.ras_n && !ddr.cas_n && !ddr.we_n;
   // Strobe reference for AL 0, CL 6
   wire [3:0]  rd_ref = dll_off ? 4'h5 : 4'h6;
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         dll_off <= 1'b0;
         viol <= 8'h00;
         in_sr_ff <= 1'b0;
      end else begin
         in_sr_ff <= !ddr.cke && (in_sr_ff || !ddr.cs_n && !ddr.ras_n);
         if (mrs && ddr.ba == 3'h1) dll_off <= ddr.addr[0];
         if (mrs && (in_sr_ff || (dll_off && ddr.ba == 3'h0 &&
             (ddr.addr[6:4] != 3'h2 || ddr.addr[8]))))
            viol <= viol + 8'h01;
      end
   end
   // Slow and prompt answers alternate
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         clk_stable <= 1'b0;
         cnt_ff <= 5'h00;
         slow_ff <= 1'b0;
      end else if (!clk_chg_req) begin
         clk_stable <= 1'b0;
         cnt_ff <= 5'h00;
      end else if (cnt_ff == (slow_ff ? 5'h0C : 5'h01)) begin
         clk_stable <= 1'b1;
         slow_ff <= slow_ff ^ !clk_stable;
      end else begin
         cnt_ff <= cnt_ff + 5'h01;
      end
   end
endmodule : dmc_dram_model
`default_nettype wire

/* tb.sv */
`timescale 1ns/1ps
`default_nettype none
module tb;
   logic                  pclk;
   logic                  presetn;
   dmc_pkg::dmc_apb_req_t req;
   dmc_pkg::dmc_ddr_t     ddr;
   logic [31:0]           prdata;
   logic [31:0]           q;
   logic                  pready;
   logic                  pslverr;
   logic                  e;
   logic                  clk_chg_req;
   logic                  clk_stable;
   logic                  wr_inhibit;
   logic                  dll_off;
   logic [7:0]            viol;
   logic [31:0]           mrv [4] = '{32'h74, 32'h244, 32'h600, 32'h0};
   logic [31:0]           bad [2] = '{32'h5, 32'h7};
   int                    n_errors;
   int                    n_compared;
   dmc_ctrl dmc_ctrl_i (.pclk(pclk), .presetn(presetn), .ce(1'b1), .apb_req(req),
      .prdata(prdata), .pready(pready), .pslverr(pslverr), .ddr(ddr),
      .clk_chg_req(clk_chg_req), .clk_stable(clk_stable), .wr_inhibit(wr_inhibit));
   dmc_dram_model dmc_dram_model_i (.pclk(pclk), .presetn(presetn), .ddr(ddr),
      .clk_chg_req(clk_chg_req), .clk_stable(clk_stable), .dll_off(dll_off), .viol(viol));
   always #2.5 pclk = ~pclk;
   task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
      n_compared++;
      if (seen !== exp) begin
         n_errors++;
         $display("wrong value %s expected %h seen %h", nm, exp, seen);
      end
   endtask : check
   // Held until the edge that samples pready
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      int n = 0;
      req <= '{1'b1, 1'b0, w, a, d};
      @(posedge pclk);
      req.penable <= 1'b1;
      do begin
         @(posedge pclk);
         n++;
      end while (pready !== 1'b1 && n < 20);
      check("pready", {31'h0, pready}, 32'h1);
      q = prdata;
      e = pslverr;
      req <= '0;
      @(posedge pclk);
   endtask : apb
   task automatic wait_idle();
      int n = 0;
      do begin
         apb(1'b0, 8'h04, 32'h0);
         n++;
      end while (q[0] !== 1'b0 && n < 300);
   endtask : wait_idle
   task automatic report_and_stop();
      $display("compared %0d mismatches %0d", n_compared, n_errors);
      if (n_errors == 0 && n_compared > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask : report_and_stop
   initial begin
      repeat (8000) @(posedge pclk);
      n_errors++;
      report_and_stop();
   end
   initial begin
      pclk = 1'b0;
      presetn = 1'b0;
      req = '0;
      n_errors = 0;
      n_compared = 0;
      repeat (4) @(posedge pclk);
      presetn <= 1'b1;
      apb(1'b0, 8'h1C, 32'h0);
      check("tMRD reset", q, 32'h10);
      apb(1'b0, 8'h38, 32'h0);
      check("unmapped", {e, q[30:0]}, 32'h80000000);
      // Short timings keep the run brief
      for (int i = 0; i < 8; i++) apb(1'b1, 8'h18 + 8'(4 * i), 32'h2);
      for (int i = 0; i < 4; i++) apb(1'b1, 8'h08 + 8'(4 * i), mrv[i]);
      apb(1'b0, 8'h0C, 32'h0);
      check("MR1 base", q, 32'h244);
      $display("test registers done");
      apb(1'b1, 8'h00, 32'h19);
      apb(1'b1, 8'h00, 32'h19);
      wait_idle();
      check("status off", q & 32'h3F, 32'h26);
      check("model dll", {31'h0, dll_off}, 32'h1);
      check("strobe ref", {28'h0, dmc_dram_model_i.rd_ref}, 32'h5);
      check("violations", {24'h0, viol}, 32'h0);
      check("odt off", {31'h0, ddr.odt}, 32'h0);
      check("write guard", {31'h0, wr_inhibit}, 32'h1);
      repeat (520) @(posedge pclk);
      check("guard end", {31'h0, wr_inhibit}, 32'h0);
      apb(1'b1, 8'h04, 32'h20);
      $display("test dll off done");
      foreach (bad[i]) begin
         apb(1'b1, 8'h00, bad[i]);
         apb(1'b0, 8'h04, 32'h0);
         check("refused", q & 32'h3F, 32'h22);
         apb(1'b1, 8'h04, 32'h20);
      end
      apb(1'b0, 8'h04, 32'h0);
      check("error cleared", q & 32'h3F, 32'h02);
      $display("test refusal done");
      apb(1'b1, 8'h00, 32'h0B);
      wait_idle();
      check("status on", q & 32'h3F, 32'h0);
      check("model dll", {31'h0, dll_off}, 32'h0);
      check("odt on", {31'h0, ddr.odt}, 32'h1);
      $display("test dll on done");
      apb(1'b1, 8'h00, 32'h0D);
      wait_idle();
      check("status ppd", q & 32'h3F, 32'h0);
      check("violations", {24'h0, viol}, 32'h0);
      $display("test power down done");
      presetn <= 1'b0;
      repeat (2) @(posedge pclk);
      presetn <= 1'b1;
      apb(1'b0, 8'h04, 32'h0);
      check("status reset", q & 32'h3F, 32'h0);
      $display("test reset done");
      report_and_stop();
   end
endmodule : tb
`default_nettype wire
